//--- hdl/direct_mapped_data_cache_ctrl.sv
/*
  Direct-mapped data cache controller: load/store port of the pipeline on
  one side, a burst-capable memory master (cache bus port) on the other.
  Assumes all inputs are on clk_sys; memory side keeps each answer valid
  until taken and accepts write responses at any time.
*/
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps

module direct_mapped_data_cache_ctrl #(
  parameter bit WRITEBACK_POLICY = 1'b1,
  parameter int CACHE_BUS_WIDTH = `DC_BUS_W_DEF,
  parameter bit PARITY_PROTECT = 1'b0,
  parameter int VICTIM_COUNT = 0,
  parameter bit LINE_MAINT_ALLOW = 1'b1,
  parameter int MMU_CONFIG = 0,
  parameter int OPT_GOAL = 0,
  parameter bit ACE_ENABLE = 1'b0,
  parameter bit [31:0] CACHEABLE_BASE = `DC_BASE_DEF,
  parameter bit [31:0] CACHEABLE_HIGH = `DC_HIGH_DEF
) (
  input logic clk_sys,
  input logic rst,
  input logic dataCacheEnable,
  input logic cpuReq,
  input logic cpuWrite,
  input logic [31:0] cpuAddr,
  input logic [31:0] cpuWdata,
  input logic [3:0] cpuBe,
  input logic cpuExcl,
  input logic cpuVirtual,
  input logic cpuPageWt,
  input logic maintReq,
  input logic maintFlush,
  input logic parityErr,
  output logic cpuBusy,
  output logic cpuDone,
  output logic [31:0] cpuRdata,
  output logic cmdValid,
  input logic cmdReady,
  output logic cmdWrite,
  output logic cmdBurst,
  output logic [1:0] cmdLen,
  output logic [31:0] cmdAddr,
  output logic wValid,
  input logic wReady,
  output logic wLast,
  output logic [CACHE_BUS_WIDTH-1:0] wData,
  output logic [CACHE_BUS_WIDTH/8-1:0] wStrb,
  input logic bValid,
  input logic rValid,
  input logic rLast,
  input logic [CACHE_BUS_WIDTH-1:0] rData
);
  import dcache_pkg::*;

  localparam int BUS_WORDS = CACHE_BUS_WIDTH / `DC_WORD_W;
  localparam bit BUS32 = (BUS_WORDS == 1);
  localparam bit MMU_SEL = (MMU_CONFIG > `DC_MMU_MIN) &&
                           (OPT_GOAL != `DC_OPT_AREA) && WRITEBACK_POLICY;
  localparam bit USE_VICT = (VICTIM_COUNT > 0) && WRITEBACK_POLICY &&
                            (OPT_GOAL != `DC_OPT_AREA);
  localparam bit [1:0] LAST_BEAT = BUS32 ? `DC_LAST_BURST : 2'h0;
  localparam bit [2:0] VLAST = 3'(VICTIM_COUNT - 1);

  dc_state_s s;
  dc_state_s next_s;

  logic [3:0] idx;
  logic [1:0] off;
  logic [1:0] lineLane;
  logic [3:0] wPos;
  logic [`DC_TAG_W-1:0] tagA;
  logic tagHit;
  logic hit;
  logic useCache;
  logic dirtyOther;
  logic vHit;
  logic [2:0] vIdx;
  logic [2:0] nValid;
  logic [1:0] firstV;
  logic doWB;
  logic doWr;
  logic doRd;
  logic rdBurst;
  logic rdFill;
  logic evict;
  logic load;
  logic [1:0] bc;
  logic [31:0] merged;
  logic [`DC_BUS_MAX-1:0] rWide;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    doWB = 1'b0;
    doWr = 1'b0;
    doRd = 1'b0;
    rdBurst = 1'b0;
    rdFill = 1'b0;
    evict = 1'b0;
    load = 1'b0;
    bc = s.cnt;
    rWide = '0;
    rWide[CACHE_BUS_WIDTH-1:0] = rData;
    idx = s.addr[`DC_IDX_LSB +: `DC_IDX_W];
    off = s.addr[`DC_OFF_LSB +: 2];
    tagA = s.addr[`DC_TAG_LSB +: `DC_TAG_W];
    lineLane = (BUS_WORDS > `DC_WORDS) ? s.addr[`DC_LANE_LSB +: 2] : 2'h0;
    wPos = BUS32 ? 4'h0 : {lineLane, off};
    // address inside the cacheable window and caching switched on
    useCache = dataCacheEnable && (s.addr >= CACHEABLE_BASE) &&
               (s.addr <= CACHEABLE_HIGH);
    tagHit = s.lv[idx] && (s.tag[idx] == tagA);
    hit = tagHit && s.wv[idx][off] &&
          !(PARITY_PROTECT && !s.wb && parityErr);
    dirtyOther = s.lv[idx] && s.dirty[idx] && !hit;
    vHit = 1'b0;
    vIdx = 3'h0;
    for (int i = 0; i < `DC_VMAX; i++) begin
      if (USE_VICT && (i < VICTIM_COUNT) && s.vv[i] &&
          (s.vtag[i] == {tagA, idx})) begin
        vHit = 1'b1;
        vIdx = 3'(i);
      end
    end
    nValid = 3'h0;
    firstV = 2'h0;
    for (int w = `DC_WORDS - 1; w >= 0; w--) begin
      if (s.wv[idx][w]) begin
        nValid = nValid + 3'h1;
        firstV = 2'(w);
      end
    end
    for (int b = 0; b < 4; b++) begin
      merged[8*b +: 8] = s.be[b] ? s.wdat[8*b +: 8] :
                         s.data[idx][off][8*b +: 8];
    end

    case (s.st)
      S_IDLE: begin
        if (cpuReq || (maintReq && LINE_MAINT_ALLOW)) begin
          next_s.busy = 1'b1;
          next_s.st = S_DECIDE;
          next_s.addr = cpuAddr;
          next_s.wdat = cpuWdata;
          next_s.be = cpuBe;
          next_s.excl = cpuExcl;
          next_s.write = cpuReq && cpuWrite;
          next_s.maint = !cpuReq;
          next_s.flush = maintFlush;
          next_s.wb = WRITEBACK_POLICY && !(MMU_SEL && cpuVirtual && cpuPageWt);
        end
      end
      S_DECIDE: begin
        if (s.maint) begin
          if (s.flush && s.lv[idx] && s.dirty[idx]) begin
            doWB = 1'b1;
          end else begin
            next_s.lv[idx] = 1'b0;
            next_s.wv[idx] = '0;
            next_s.dirty[idx] = 1'b0;
            next_s.done = 1'b1;
            next_s.busy = 1'b0;
            next_s.st = S_IDLE;
          end
        end else if (!useCache) begin
          if (s.write) begin
            doWr = 1'b1;
          end else begin
            doRd = 1'b1;
            rdBurst = BUS32 && (s.wb ? !s.excl : (s.excl && ACE_ENABLE));
          end
        end else if (hit && !s.write) begin
          next_s.rdat = s.data[idx][off];
          next_s.done = 1'b1;
          next_s.busy = 1'b0;
          next_s.st = S_IDLE;
        end else if (hit) begin
          next_s.data[idx][off] = merged;
          if (s.wb) begin
            next_s.dirty[idx] = 1'b1;
            next_s.done = 1'b1;
            next_s.busy = 1'b0;
            next_s.st = S_IDLE;
          end else begin
            doWr = 1'b1;
          end
        end else if (dirtyOther) begin
          doWB = 1'b1;
        end else if (vHit) begin
          next_s.vsel = vIdx;
          next_s.cnt = 2'h0;
          next_s.st = S_V_SWAP;
        end else if (s.write && !s.wb) begin
          doWr = 1'b1;
        end else if (s.write && (s.be == `DC_BE_FULL)) begin
          evict = !tagHit;
          if (!tagHit) begin
            next_s.wv[idx] = '0;
          end
          next_s.tag[idx] = tagA;
          next_s.lv[idx] = 1'b1;
          next_s.wv[idx][off] = 1'b1;
          next_s.data[idx][off] = s.wdat;
          next_s.dirty[idx] = 1'b1;
          next_s.done = 1'b1;
          next_s.busy = 1'b0;
          next_s.st = S_IDLE;
        end else if (!s.wb && s.excl && !ACE_ENABLE) begin
          doRd = 1'b1;
        end else begin
          doRd = 1'b1;
          rdFill = 1'b1;
          rdBurst = BUS32;
        end
      end
      S_W_CMD: begin
        if (cmdReady) begin
          next_s.cmdValid = 1'b0;
          next_s.wValid = 1'b1;
          load = 1'b1;
          next_s.st = S_W_DAT;
        end
      end
      S_W_DAT: begin
        if (wReady) begin
          if (s.wLast) begin
            next_s.wValid = 1'b0;
            next_s.st = S_W_RSP;
          end else begin
            next_s.cnt = s.cnt + 2'h1;
            bc = s.cnt + 2'h1;
            load = 1'b1;
          end
        end
      end
      S_W_RSP: begin
        if (bValid) begin
          next_s.st = s.after;
          if (s.fromLine) begin
            next_s.dirty[idx] = 1'b0;
          end else begin
            next_s.done = 1'b1;
            next_s.busy = 1'b0;
          end
        end
      end
      S_R_CMD: begin
        if (cmdReady) begin
          next_s.cmdValid = 1'b0;
          next_s.cnt = 2'h0;
          next_s.st = S_R_DAT;
        end
      end
      S_R_DAT: begin
        if (rValid) begin
          next_s.cnt = s.cnt + 2'h1;
          if (s.fill && BUS32) begin
            next_s.data[idx][s.cnt] = rWide[31:0];
            next_s.wv[idx][s.cnt] = 1'b1;
          end else if (s.fill) begin
            for (int w = 0; w < `DC_WORDS; w++) begin
              next_s.data[idx][w] = rWide[{lineLane, 2'(w), 5'h0} +: 32];
            end
            next_s.wv[idx] = '1;
          end else if (s.keepOne) begin
            // wanted word parked until the burst ends
            if (s.cnt == off) begin
              next_s.wdat = rWide[31:0];
            end
            if (rLast) begin
              next_s.rdat = (s.cnt == off) ? rWide[31:0] : s.wdat;
            end
          end else begin
            next_s.rdat = rWide[{wPos, 5'h0} +: 32];
          end
          if (rLast && s.fill) begin
            next_s.tag[idx] = tagA;
            next_s.lv[idx] = 1'b1;
            next_s.dirty[idx] = 1'b0;
            next_s.st = S_DECIDE;
          end else if (rLast) begin
            next_s.done = 1'b1;
            next_s.busy = 1'b0;
            next_s.st = S_IDLE;
          end
        end
      end
      S_V_SWAP: begin
        // whole line swapped in one cycle once cnt reaches LAST_BEAT
        next_s.cnt = s.cnt + 2'h1;
        if (s.cnt == LAST_BEAT) begin
          next_s.vdata[s.vsel] = s.data[idx];
          next_s.vtag[s.vsel] = {s.tag[idx], idx};
          next_s.vv[s.vsel] = s.lv[idx] && (&s.wv[idx]);
          next_s.data[idx] = s.vdata[s.vsel];
          next_s.tag[idx] = s.vtag[s.vsel][`DC_VTAG_W-1 -: `DC_TAG_W];
          next_s.wv[idx] = '1;
          next_s.lv[idx] = 1'b1;
          next_s.dirty[idx] = 1'b0;
          next_s.st = S_DECIDE;
        end
      end
      default: begin
        next_s.st = S_IDLE;
      end
    endcase

    if (doWB) begin
      next_s.cmdValid = 1'b1;
      next_s.cmdWrite = 1'b1;
      next_s.fromLine = 1'b1;
      next_s.after = S_DECIDE;
      next_s.st = S_W_CMD;
      next_s.cmdAddr = {s.tag[idx], idx, 4'h0};
      next_s.cmdLen = 2'h0;
      next_s.cmdBurst = 1'b0;
      next_s.cnt = 2'h0;
      next_s.last = 2'h0;
      if (BUS32 && (nValid > 3'h1)) begin
        next_s.cmdBurst = 1'b1;
        next_s.cmdLen = `DC_LAST_BURST;
        next_s.last = `DC_LAST_BURST;
      end else if (BUS32) begin
        next_s.cmdAddr = {s.tag[idx], idx, firstV, 2'h0};
        next_s.cnt = firstV;
        next_s.last = firstV;
      end
    end
    if (doWr) begin
      next_s.cmdValid = 1'b1;
      next_s.cmdWrite = 1'b1;
      next_s.fromLine = 1'b0;
      next_s.after = S_IDLE;
      next_s.cmdAddr = {s.addr[31:2], 2'h0};
      next_s.cmdBurst = 1'b0;
      next_s.cmdLen = 2'h0;
      next_s.cnt = 2'h0;
      next_s.last = 2'h0;
      next_s.st = S_W_CMD;
    end
    if (doRd) begin
      next_s.cmdValid = 1'b1;
      next_s.cmdWrite = 1'b0;
      next_s.cmdBurst = rdBurst;
      next_s.cmdLen = rdBurst ? `DC_LAST_BURST : 2'h0;
      next_s.cmdAddr = (rdBurst || rdFill) ? {s.addr[31:4], 4'h0} :
                       {s.addr[31:2], 2'h0};
      next_s.fill = rdFill;
      next_s.keepOne = rdBurst && !rdFill;
      next_s.st = S_R_CMD;
      evict = rdFill;
    end
    // complete lines replaced by a refill or a full-word store miss go to the victim buffer
    if (evict && USE_VICT && s.lv[idx] && (&s.wv[idx])) begin
      next_s.vdata[s.vptr] = s.data[idx];
      next_s.vtag[s.vptr] = {s.tag[idx], idx};
      next_s.vv[s.vptr] = 1'b1;
      next_s.vptr = (s.vptr == VLAST) ? 3'h0 : s.vptr + 3'h1;
    end
    if (doRd && rdFill) begin
      next_s.lv[idx] = 1'b0;
      next_s.wv[idx] = '0;
      next_s.dirty[idx] = 1'b0;
    end
    if (load) begin
      next_s.wLast = (bc == s.last);
      next_s.wData = '0;
      next_s.wStrb = '0;
      if (!s.fromLine) begin
        next_s.wData[{wPos, 5'h0} +: 32] = s.wdat;
        next_s.wStrb[{wPos, 2'h0} +: 4] = s.be;
      end else if (BUS32) begin
        next_s.wData[31:0] = s.data[idx][bc];
        next_s.wStrb[3:0] = {4{s.wv[idx][bc]}};
      end else begin
        for (int w = 0; w < `DC_WORDS; w++) begin
          next_s.wData[{lineLane, 2'(w), 5'h0} +: 32] = s.data[idx][w];
          next_s.wStrb[{lineLane, 2'(w), 2'h0} +: 4] = {4{s.wv[idx][w]}};
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cpuBusy = s.busy;
  assign cpuDone = s.done;
  assign cpuRdata = s.rdat;
  assign cmdValid = s.cmdValid;
  assign cmdWrite = s.cmdWrite;
  assign cmdBurst = s.cmdBurst;
  assign cmdLen = s.cmdLen;
  assign cmdAddr = s.cmdAddr;
  assign wValid = s.wValid;
  assign wLast = s.wLast;
  assign wData = s.wData[CACHE_BUS_WIDTH-1:0];
  assign wStrb = s.wStrb[CACHE_BUS_WIDTH/8-1:0];

endmodule

//--- hdl/dcache_defs.svh
/*
  Constants of the direct-mapped data cache controller: geometry, address
  fields, bus limits and encodings.
  Assumes nothing; included by the package file; the controller uses its macros without including it.
*/
`ifndef DCACHE_DEFS_SVH
`define DCACHE_DEFS_SVH

`define DC_WORD_W 32
`define DC_WORDS 4
`define DC_LINES 16
`define DC_OFF_LSB 2
`define DC_IDX_LSB 4
`define DC_IDX_W 4
`define DC_TAG_LSB 8
`define DC_TAG_W 24
`define DC_LANE_LSB 4
`define DC_VMAX 8
`define DC_VTAG_W 28
`define DC_BUS_MAX 512
`define DC_STRB_MAX 64
`define DC_BUS_W_DEF 32
`define DC_BE_FULL 4'hF
`define DC_LAST_BURST 2'h3
`define DC_OPT_AREA 1
`define DC_MMU_MIN 1
`define DC_BASE_DEF 32'h0040_0000
`define DC_HIGH_DEF 32'h0040_3FFF

`endif

//--- hdl/dcache_pkg.sv
/*
  Types of the data cache controller: controller states and the packed
  state record that holds every flip-flop of the block.
  Assumes dcache_defs.svh is on the include path.
*/
`include "dcache_defs.svh"

package dcache_pkg;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_DECIDE = 4'b0001,
    S_W_CMD  = 4'b0010,
    S_W_DAT  = 4'b0011,
    S_W_RSP  = 4'b0100,
    S_R_CMD  = 4'b0101,
    S_R_DAT  = 4'b0110,
    S_V_SWAP = 4'b0111
  } dc_state_e;

  typedef logic [`DC_WORD_W-1:0] word_t;
  typedef word_t [`DC_WORDS-1:0] line_t;

  typedef struct packed {
    dc_state_e st;
    dc_state_e after;
    logic wb;
    logic write;
    logic excl;
    logic maint;
    logic flush;
    logic fill;
    logic keepOne;
    logic fromLine;
    logic busy;
    logic done;
    word_t addr;
    word_t wdat;
    word_t rdat;
    logic [3:0] be;
    logic [1:0] cnt;
    logic [1:0] last;
    logic cmdValid;
    logic cmdWrite;
    logic cmdBurst;
    logic [1:0] cmdLen;
    word_t cmdAddr;
    logic wValid;
    logic wLast;
    logic [`DC_BUS_MAX-1:0] wData;
    logic [`DC_STRB_MAX-1:0] wStrb;
    line_t [`DC_LINES-1:0] data;
    logic [`DC_LINES-1:0][`DC_TAG_W-1:0] tag;
    logic [`DC_LINES-1:0][`DC_WORDS-1:0] wv;
    logic [`DC_LINES-1:0] lv;
    logic [`DC_LINES-1:0] dirty;
    logic [`DC_VMAX-1:0] vv;
    logic [`DC_VMAX-1:0][`DC_VTAG_W-1:0] vtag;
    line_t [`DC_VMAX-1:0] vdata;
    logic [2:0] vptr;
    logic [2:0] vsel;
  } dc_state_s;

endpackage

//--- testbench/dcache_props.sv
/*
  Port checker of the data cache controller.
  Assumes a bind onto the controller; one clock, reset rst.
*/
`timescale 1ns/10ps
module dcache_props #(
  parameter int CACHE_BUS_WIDTH = 32
) (
  input logic clk_sys,
  input logic rst,
  input logic cpuReq,
  input logic cpuBusy,
  input logic cpuDone,
  input logic [31:0] cpuRdata,
  input logic cmdValid,
  input logic cmdReady,
  input logic cmdWrite,
  input logic cmdBurst,
  input logic [1:0] cmdLen,
  input logic [31:0] cmdAddr,
  input logic wValid,
  input logic wReady,
  input logic wLast,
  input logic [CACHE_BUS_WIDTH-1:0] wData
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [1:0] beats;
  logic [1:0] lenHeld;
  always_ff @(posedge clk_sys) begin
    if (rst || (cmdValid && cmdReady)) begin
      beats <= 2'h0;
      lenHeld <= cmdLen;
    end else if (wValid && wReady) begin
      beats <= beats + 2'h1;
    end
  end
  req_taken_a: assert property (cpuReq && !cpuBusy |=> cpuBusy)
    else $error("request not taken");
  done_ends_a: assert property (cpuDone |-> $past(cpuBusy) && !cpuBusy)
    else $error("done without busy");
  done_pulse_a: assert property (cpuDone |=> !cpuDone)
    else $error("done longer than one cycle");
  cmd_hold_a: assert property (cmdValid && !cmdReady |=> cmdValid &&
    $stable(cmdAddr) && $stable(cmdWrite) && $stable(cmdBurst))
    else $error("command changed before taken");
  beat_hold_a: assert property (wValid && !wReady |=> wValid &&
    $stable(wData) && $stable(wLast))
    else $error("write beat changed before taken");
  burst_shape_a: assert property (cmdValid |-> (cmdBurst ?
    cmdLen == 2'h3 && cmdAddr[3:0] == 4'h0 : cmdLen == 2'h0))
    else $error("burst length or alignment wrong");
  beat_count_a: assert property (wValid && wReady && wLast |->
    beats == lenHeld) else $error("beat count differs from length");
  data_follows_a: assert property (cmdValid && cmdReady && cmdWrite
    |=> wValid ##0 !cmdValid) else $error("write data missing");
  rdata_hold_a: assert property ($changed(cpuRdata) |-> cpuDone)
    else $error("read data changed without done");
  cover property (cmdValid && cmdReady && cmdWrite && cmdBurst);
  cover property (cmdValid && cmdReady && cmdWrite && !cmdBurst);
  cover property (cmdValid && !cmdReady);
endmodule

//--- testbench/dcache_mem_model.sv
/*
  Behavioural memory behind the cache bus port.
  Assumes one transaction at a time; slow delays command acceptance
  and every write beat.
*/
`timescale 1ns/10ps
module dcache_mem_model (
  input logic clk_sys,
  input logic rst,
  input logic [1:0] slow,
  input logic cmdValid,
  input logic cmdWrite,
  input logic cmdBurst,
  input logic [31:0] cmdAddr,
  input logic wValid,
  input logic [31:0] wData,
  input logic [3:0] wStrb,
  output logic cmdReady,
  output logic wReady,
  output logic bValid,
  output logic rValid,
  output logic rLast,
  output logic [31:0] rData
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] a;
  logic [31:0] v;
  logic wr;
  int n;
  function automatic logic [31:0] rd(input logic [31:0] x);
    return mem.exists(x) ? mem[x] : {x[15:0], ~x[15:0]};
  endfunction
  initial begin
    {cmdReady, wReady, bValid, rValid, rLast} = 5'h0;
    rData = 32'h0;
    forever begin
      @(posedge clk_sys);
      if (cmdValid === 1'b1 && rst === 1'b0) begin
        repeat (slow) @(posedge clk_sys);
        cmdReady <= 1'b1;
        @(posedge clk_sys);
        a = cmdAddr;
        wr = cmdWrite;
        n = cmdBurst ? 4 : 1;
        cmdReady <= 1'b0;
        for (int k = 0; k < n; k++) begin
          if (wr) begin
            // a slow memory also stalls each write beat
            if (slow != 2'h0) begin
              wReady <= 1'b0;
              repeat (slow) @(posedge clk_sys);
            end
            wReady <= 1'b1;
            do @(posedge clk_sys); while (wValid !== 1'b1);
            v = rd(a);
            for (int b = 0; b < 4; b++) begin
              if (wStrb[b]) v[8*b +: 8] = wData[8*b +: 8];
            end
            mem[a] = v;
          end else begin
            rValid <= 1'b1;
            rData <= rd(a);
            rLast <= (k == n - 1);
            @(posedge clk_sys);
          end
          a = a + 32'h4;
        end
        // released data lines show the inverse, not a stale value
        {wReady, rValid, rLast} <= 3'h0;
        rData <= ~rData;
        if (wr) begin
          bValid <= 1'b1;
          @(posedge clk_sys);
          bValid <= 1'b0;
        end
      end
    end
  end
endmodule

//--- testbench/tb_direct_mapped_data_cache_ctrl.sv
/*
  Self-checking bench of the data cache controller, write-back, 32 bits;
  virtual pages marked write-through exercise the other policy.
  Assumes the memory model and the port checker beside it.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  miscompares++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
  end end
module tb_direct_mapped_data_cache_ctrl;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic dataCacheEnable = 1'b1, cpuReq = 1'b0, cpuWrite = 1'b0;
  logic maintReq = 1'b0, maintFlush = 1'b0;
  logic cpuExcl = 1'b0, cpuVirtual = 1'b0, cpuPageWt = 1'b0;
  logic parityArm = 1'b0;
  logic parityErr;
  logic [31:0] cpuAddr = 32'h0, cpuWdata = 32'h0;
  logic [3:0] cpuBe = 4'h0;
  logic [1:0] slow = 2'h0;
  logic cpuBusy, cpuDone, cmdValid, cmdReady, cmdWrite, cmdBurst;
  logic wValid, wReady, wLast, bValid, rValid, rLast;
  logic [1:0] cmdLen;
  logic [31:0] cpuRdata, cmdAddr, wData, rData, e, semWord;
  logic [3:0] wStrb;
  logic [35:0] log[$];
  int miscompares = 0, comparisons = 0;
  localparam logic [31:0] A = 32'h0040_0010, B = 32'h0040_0110;
  localparam logic [31:0] C = 32'h0040_0120, U = 32'h0000_1004;
  localparam logic [31:0] D1 = 32'h1234_5678, D2 = 32'h9ABC_DEF0;
  localparam logic [31:0] W = 32'h0040_0230, Q = 32'h0040_0340;
  always #12.5 clk_sys = ~clk_sys;
  direct_mapped_data_cache_ctrl #(.PARITY_PROTECT(1'b1), .MMU_CONFIG(2))
    u_dut (.clk_sys(clk_sys), .rst(rst),
    .dataCacheEnable(dataCacheEnable), .cpuReq(cpuReq), .cpuWrite(cpuWrite),
    .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuBe(cpuBe),
    .cpuExcl(cpuExcl), .cpuVirtual(cpuVirtual), .cpuPageWt(cpuPageWt),
    .maintReq(maintReq), .maintFlush(maintFlush), .parityErr(parityErr),
    .cpuBusy(cpuBusy),
    .cpuDone(cpuDone), .cpuRdata(cpuRdata), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdBurst(cmdBurst),
    .cmdLen(cmdLen), .cmdAddr(cmdAddr), .wValid(wValid), .wReady(wReady),
    .wLast(wLast), .wData(wData), .wStrb(wStrb), .bValid(bValid),
    .rValid(rValid), .rLast(rLast), .rData(rData));
  dcache_mem_model u_mem (.clk_sys(clk_sys), .rst(rst), .slow(slow),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdBurst(cmdBurst),
    .cmdAddr(cmdAddr), .wValid(wValid), .wData(wData), .wStrb(wStrb),
    .cmdReady(cmdReady), .wReady(wReady), .bValid(bValid),
    .rValid(rValid), .rLast(rLast), .rData(rData));
  always @(posedge clk_sys) begin
    if (cmdValid === 1'b1 && cmdReady === 1'b1) begin
      log.push_back({cmdWrite, cmdBurst, cmdLen, cmdAddr});
    end
  end
  // parity fault only during the first lookup of an armed request
  always @(posedge clk_sys) begin
    parityErr <= parityArm && cpuReq;
  end
  function automatic logic [31:0] pat(input logic [31:0] x);
    return {x[15:0], ~x[15:0]};
  endfunction
  task automatic access(input logic wr, input logic [31:0] a,
      input logic [31:0] d, input logic [3:0] be, input logic mt,
      input logic fl);
    int i;
    @(posedge clk_sys);
    cpuReq <= !mt;
    maintReq <= mt;
    maintFlush <= fl;
    cpuWrite <= wr;
    cpuAddr <= a;
    cpuWdata <= d;
    cpuBe <= be;
    @(posedge clk_sys);
    cpuReq <= 1'b0;
    maintReq <= 1'b0;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (cpuDone !== 1'b1 && i < 300);
    `CHK(cpuDone, 1'b1)
  endtask
  task automatic ld(input logic [31:0] a, input logic [31:0] x);
    access(1'b0, a, 32'h0, 4'h0, 1'b0, 1'b0);
    `CHK(cpuRdata, x)
  endtask
  task automatic cmd(input logic w, input logic b, input logic [31:0] a);
    logic [35:0] got;
    got = 'x;
    if (log.size() > 0) got = log.pop_front();
    `CHK(got, {w, b, b ? 2'h3 : 2'h0, a})
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    ld(A, pat(A));
    cmd(1'b0, 1'b1, A);
    ld(A + 32'h4, pat(A + 32'h4));
    `CHK(log.size(), 0)
    access(1'b1, A + 32'h8, D1, 4'hF, 1'b0, 1'b0);
    ld(A + 32'h8, D1);
    `CHK(log.size(), 0)
    $display("test refill and hit done");
    slow <= 2'h2;
    access(1'b1, B, D2, 4'hF, 1'b0, 1'b0);
    cmd(1'b1, 1'b1, A);
    `CHK(log.size(), 0)
    `CHK(u_mem.mem[A + 32'h8], D1)
    ld(B, D2);
    ld(A, pat(A));
    cmd(1'b1, 1'b0, B);
    cmd(1'b0, 1'b1, A);
    `CHK(u_mem.mem[B], D2)
    $display("test eviction done");
    access(1'b1, C + 32'h4, 32'h0000_AB00, 4'h2, 1'b0, 1'b0);
    cmd(1'b0, 1'b1, C);
    e = pat(C + 32'h4);
    e[15:8] = 8'hAB;
    ld(C + 32'h4, e);
    `CHK(log.size(), 0)
    $display("test partial store done");
    repeat (2) begin
      ld(U, pat(U));
      cmd(1'b0, 1'b1, 32'h0000_1000);
    end
    access(1'b1, U, D1, 4'h3, 1'b0, 1'b0);
    cmd(1'b1, 1'b0, U);
    semWord = pat(U);
    semWord[15:0] = D1[15:0];
    `CHK(u_mem.mem[U], semWord)
    cpuExcl <= 1'b1;
    ld(U, semWord);
    cpuExcl <= 1'b0;
    cmd(1'b0, 1'b0, U);
    dataCacheEnable <= 1'b0;
    ld(A + 32'h4, pat(A + 32'h4));
    cmd(1'b0, 1'b1, A);
    dataCacheEnable <= 1'b1;
    ld(A + 32'h8, D1);
    `CHK(log.size(), 0)
    $display("test bypass and enable done");
    access(1'b0, C, 32'h0, 4'h0, 1'b1, 1'b1);
    cmd(1'b1, 1'b1, C);
    `CHK(u_mem.mem[C + 32'h4], e)
    ld(C + 32'h4, e);
    cmd(1'b0, 1'b1, C);
    access(1'b0, A, 32'h0, 4'h0, 1'b1, 1'b0);
    `CHK(log.size(), 0)
    ld(A + 32'h8, D1);
    cmd(1'b0, 1'b1, A);
    $display("test maintenance done");
    cpuVirtual <= 1'b1;
    cpuPageWt <= 1'b1;
    access(1'b1, W, D2, 4'hF, 1'b0, 1'b0);
    cmd(1'b1, 1'b0, W);
    `CHK(u_mem.mem[W], D2)
    ld(W, D2);
    cmd(1'b0, 1'b1, W);
    access(1'b1, W + 32'h4, 32'h0000_00C3, 4'h1, 1'b0, 1'b0);
    cmd(1'b1, 1'b0, W + 32'h4);
    semWord = pat(W + 32'h4);
    semWord[7:0] = 8'hC3;
    `CHK(u_mem.mem[W + 32'h4], semWord)
    ld(W + 32'h4, semWord);
    `CHK(log.size(), 0)
    parityArm <= 1'b1;
    ld(W, D2);
    parityArm <= 1'b0;
    cmd(1'b0, 1'b1, W);
    cpuExcl <= 1'b1;
    ld(Q, pat(Q));
    cpuExcl <= 1'b0;
    cmd(1'b0, 1'b0, Q);
    ld(Q, pat(Q));
    cmd(1'b0, 1'b1, Q);
    $display("test write-through done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end
endmodule
bind direct_mapped_data_cache_ctrl dcache_props #(
  .CACHE_BUS_WIDTH(CACHE_BUS_WIDTH)) u_props (.clk_sys(clk_sys),
  .rst(rst), .cpuReq(cpuReq), .cpuBusy(cpuBusy), .cpuDone(cpuDone),
  .cpuRdata(cpuRdata), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .cmdWrite(cmdWrite), .cmdBurst(cmdBurst), .cmdLen(cmdLen),
  .cmdAddr(cmdAddr), .wValid(wValid), .wReady(wReady), .wLast(wLast),
  .wData(wData));
